// ===== rtl/radio_power_pkg.sv
// constants and types shared by the radio power enable and reset controller
// Overview of operation
// - in shutdown all outputs float and most input receivers are disabled
// - leaving shutdown performs a full power-up; no internal state survives
// - wlan enable high turns regulators on and releases wlan section reset
// - wlan enable low holds wlan section in reset whatever bt enable does
// - regulator enable is OR of both enables; off only when both low
// - each enable has a pull-down on after reset, separately switchable off
// - reference clock input buffer is off in sleep, on when sleep ends
// - bt enable high takes the bluetooth section out of reset
package radio_power_pkg;
	localparam int SYNC_STAGES = 3;
	localparam logic RESET_ACTIVE = 1'h1;
	localparam logic PULL_ON_RESET = 1'h1;
	localparam logic BUF_ON_RESET = 1'h1;
	localparam logic OFF_ON_RESET = 1'h0;
	localparam logic [1:0] SYNC_ZERO = 2'h0;

	typedef enum logic [2:0] {
		ST_SHUTDOWN = 3'h1,
		ST_ACTIVE = 3'h2,
		ST_SLEEP = 3'h4
	} power_state_e;
endpackage

// ===== rtl/pin_filter.sv
// three-stage pin synchroniser that accepts a change when stages two and three agree
`timescale 1ns/1ns
module pin_filter (
	input wire logic clk,
	input wire logic srst,
	input wire logic pinIn,
	output logic level
);
	logic meta_ff;
	logic [1:0] stage_ff;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_ff <= radio_power_pkg::OFF_ON_RESET;
			stage_ff <= radio_power_pkg::SYNC_ZERO;
		end else begin
			meta_ff <= pinIn;
			stage_ff <= {stage_ff[0], meta_ff};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			level <= radio_power_pkg::OFF_ON_RESET;
		end else if (stage_ff[0] == stage_ff[1]) begin
			level <= stage_ff[1];
		end
	end
endmodule

// ===== rtl/radio_power_enable_reset_ctrl.sv
// power enable and reset controller for the wlan and bluetooth radio sections
`timescale 1ns/1ns
module radio_power_enable_reset_ctrl (
	input wire logic clk,
	input wire logic srst,
	input wire logic wlan_power_on_ctl,
	input wire logic bt_power_on_ctl,
	input wire logic sleepReq,
	input wire logic wlanPullDis,
	input wire logic btPullDis,
	output logic regulatorEn,
	output logic wlanResetN,
	output logic btResetN,
	output logic wlanPullEn,
	output logic btPullEn,
	output logic refClkBufEn,
	output logic inputRxEn,
	output logic outputEn,
	output logic stateClear
);
	logic wlanOn;
	logic btOn;
	logic anyOn;
	radio_power_pkg::power_state_e state_ff;
	radio_power_pkg::power_state_e nxt_state;

	// outputs and receivers are live in every state but shutdown
	function automatic logic isPowered(input radio_power_pkg::power_state_e st);
		return st != radio_power_pkg::ST_SHUTDOWN;
	endfunction

	// the enables come from the host's own clock domain, so they are filtered first
	pin_filter wlanSync (
		.clk(clk),
		.srst(srst),
		.pinIn(wlan_power_on_ctl),
		.level(wlanOn)
	);
	pin_filter btSync (
		.clk(clk),
		.srst(srst),
		.pinIn(bt_power_on_ctl),
		.level(btOn)
	);

	assign anyOn = wlanOn | btOn;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			radio_power_pkg::ST_SHUTDOWN: begin
				if (anyOn) begin
					nxt_state = radio_power_pkg::ST_ACTIVE;
				end
			end
			radio_power_pkg::ST_ACTIVE: begin
				if (!anyOn) begin
					nxt_state = radio_power_pkg::ST_SHUTDOWN;
				end else if (sleepReq) begin
					nxt_state = radio_power_pkg::ST_SLEEP;
				end
			end
			radio_power_pkg::ST_SLEEP: begin
				if (!anyOn) begin
					nxt_state = radio_power_pkg::ST_SHUTDOWN;
				end else if (!sleepReq) begin
					nxt_state = radio_power_pkg::ST_ACTIVE;
				end
			end
			default: begin
				nxt_state = radio_power_pkg::ST_SHUTDOWN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff <= radio_power_pkg::ST_SHUTDOWN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// regulators and section resets follow the filtered enables directly
	always_ff @(posedge clk) begin
		if (srst) begin
			// regulators off and both sections held while srst is high
			regulatorEn <= radio_power_pkg::OFF_ON_RESET;
			wlanResetN <= radio_power_pkg::OFF_ON_RESET;
			btResetN <= radio_power_pkg::OFF_ON_RESET;
		end else begin
			regulatorEn <= anyOn;
			wlanResetN <= wlanOn;
			btResetN <= btOn;
		end
	end

	// pull-downs stay on until programming turns them off; a host that floats
	// its pin still sees the enable held low
	always_ff @(posedge clk) begin
		if (srst) begin
			wlanPullEn <= radio_power_pkg::PULL_ON_RESET;
			btPullEn <= radio_power_pkg::PULL_ON_RESET;
		end else begin
			wlanPullEn <= !wlanPullDis;
			btPullEn <= !btPullDis;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			refClkBufEn <= radio_power_pkg::BUF_ON_RESET;
		end else begin
			refClkBufEn <= (nxt_state != radio_power_pkg::ST_SLEEP);
		end
	end

	// shutdown floats outputs and idles receivers; the enable pins keep their receivers
	always_ff @(posedge clk) begin
		if (srst) begin
			inputRxEn <= radio_power_pkg::OFF_ON_RESET;
			outputEn <= radio_power_pkg::OFF_ON_RESET;
		end else begin
			// taken from the next state so the pins switch on the same edge as the state
			inputRxEn <= isPowered(nxt_state);
			outputEn <= isPowered(nxt_state);
		end
	end

	// one-cycle pulse on leaving shutdown: downstream state is wiped, nothing retained
	always_ff @(posedge clk) begin
		if (srst) begin
			stateClear <= radio_power_pkg::OFF_ON_RESET;
		end else begin
			stateClear <= (state_ff == radio_power_pkg::ST_SHUTDOWN) && anyOn;
		end
	end

	// checks on the filtered enables; regulator, resets and pulls follow one edge later, the buffer and pin enables switch with the state
	chk_wlan_reset_follow: assert property (@(posedge clk) disable iff (srst)
		wlanOn |=> wlanResetN) else $error("wlan reset not released");
	chk_wlan_reset_hold: assert property (@(posedge clk) disable iff (srst)
		!wlanOn |=> !wlanResetN) else $error("wlan reset not held");
	chk_regulator_or: assert property (@(posedge clk) disable iff (srst)
		##1 (regulatorEn == ($past(wlanOn) | $past(btOn)))) else $error("regulator not OR of enables");
	chk_bt_reset_follow: assert property (@(posedge clk) disable iff (srst)
		##1 (btResetN == $past(btOn))) else $error("bt reset mismatch");
	chk_pull_default: assert property (@(posedge clk)
		srst |=> (wlanPullEn && btPullEn)) else $error("pull-down not on after reset");
	// srst is also tested as sampled: the release edge still applies the reset values,
	// so a pull-down switched off across a release must not count as a failure
	chk_pull_disable: assert property (@(posedge clk) disable iff (srst)
		(!srst && wlanPullDis) |=> !wlanPullEn) else $error("wlan pull-down not disabled");
	chk_bt_pull_disable: assert property (@(posedge clk) disable iff (srst)
		(!srst && btPullDis) |=> !btPullEn)
		else $error("bt pull-down not disabled");
	chk_wlan_pull_enable: assert property (@(posedge clk) disable iff (srst)
		(!srst && !wlanPullDis) |=> wlanPullEn)
		else $error("wlan pull-down not restored");
	chk_bt_pull_enable: assert property (@(posedge clk) disable iff (srst)
		(!srst && !btPullDis) |=> btPullEn)
		else $error("bt pull-down not restored");
	chk_refbuf_sleep: assert property (@(posedge clk) disable iff (srst)
		(state_ff == radio_power_pkg::ST_SLEEP) |-> !refClkBufEn) else $error("ref buffer on in sleep");
	sequence wakeSeq;
		(state_ff == radio_power_pkg::ST_SHUTDOWN) && anyOn;
	endsequence
	chk_wake_clear: assert property (@(posedge clk) disable iff (srst)
		wakeSeq |=> stateClear ##1 !stateClear) else $error("no state clear on wake");
	chk_shutdown_float: assert property (@(posedge clk) disable iff (srst)
		(state_ff == radio_power_pkg::ST_SHUTDOWN) |-> (!outputEn && !inputRxEn))
		else $error("outputs driven in shutdown");

	// outside shutdown the pins are driven and listened to again
	chk_awake_driven: assert property (@(posedge clk) disable iff (srst)
		(state_ff != radio_power_pkg::ST_SHUTDOWN) |-> (outputEn && inputRxEn))
		else $error("outputs floated while powered");
	chk_wake_drive: assert property (@(posedge clk) disable iff (srst)
		wakeSeq |=> (outputEn && inputRxEn))
		else $error("outputs not driven after wake");
	chk_clear_only_wake: assert property (@(posedge clk) disable iff (srst)
		!((state_ff == radio_power_pkg::ST_SHUTDOWN) && anyOn) |=> !stateClear)
		else $error("state clear without wake");

	// bt enable alone powers the regulators but must not wake the wlan section
	chk_wlan_ignores_bt: assert property (@(posedge clk) disable iff (srst)
		(!wlanOn && btOn) |=> (!wlanResetN && btResetN && regulatorEn))
		else $error("wlan reset follows bt enable");
	chk_bt_reset_hold: assert property (@(posedge clk) disable iff (srst)
		!btOn |=> !btResetN)
		else $error("bt reset not held");

	// with both enables low the regulators drop and the block goes to shutdown
	sequence allOffSeq;
		!wlanOn && !btOn;
	endsequence
	chk_regulator_off: assert property (@(posedge clk) disable iff (srst)
		allOffSeq |=> !regulatorEn)
		else $error("regulator on with both enables low");
	chk_off_to_shutdown: assert property (@(posedge clk) disable iff (srst)
		allOffSeq |=> (state_ff == radio_power_pkg::ST_SHUTDOWN))
		else $error("no shutdown with both enables low");

	// sleep only follows active; the buffer tracks the state register edge for edge
	sequence sleepEntrySeq;
		(state_ff == radio_power_pkg::ST_ACTIVE) && anyOn && sleepReq;
	endsequence
	sequence sleepExitSeq;
		(state_ff == radio_power_pkg::ST_SLEEP) && anyOn && !sleepReq;
	endsequence
	chk_sleep_entry: assert property (@(posedge clk) disable iff (srst)
		sleepEntrySeq |=> ((state_ff == radio_power_pkg::ST_SLEEP) && !refClkBufEn))
		else $error("ref buffer not off on sleep entry");
	chk_sleep_exit: assert property (@(posedge clk) disable iff (srst)
		sleepExitSeq |=> ((state_ff == radio_power_pkg::ST_ACTIVE) && refClkBufEn))
		else $error("ref buffer not on after sleep");
	chk_refbuf_awake: assert property (@(posedge clk) disable iff (srst)
		(state_ff != radio_power_pkg::ST_SLEEP) |-> refClkBufEn)
		else $error("ref buffer off outside sleep");
	// a sleep request with both enables low is ignored
	chk_no_sleep_from_off: assert property (@(posedge clk) disable iff (srst)
		(state_ff == radio_power_pkg::ST_SHUTDOWN) |=> (state_ff != radio_power_pkg::ST_SLEEP))
		else $error("sleep entered from shutdown");
endmodule

// ===== verification/host_pin_driver.sv
// host model holding both section enable pins at defined levels
`timescale 1ns/1ns
module host_pin_driver (
	input wire logic clk,
	input wire logic [1:0] req,
	output logic wlanPin,
	output logic btPin
);
	// pins start low and never float, so no section can leave reset by accident
	logic [1:0] pins_ff = 2'h0;
	always @(posedge clk) pins_ff <= req;
	assign wlanPin = pins_ff[1];
	assign btPin = pins_ff[0];
endmodule

// ===== verification/test_radio_power_enable_reset_ctrl.sv
// self-checking bench for the radio power enable and reset controller
`timescale 1ns/1ns
module test_radio_power_enable_reset_ctrl;
	logic clk = 1'h0, srst = 1'h1, sleepReq = 1'h0, wlanPullDis = 1'h0, btPullDis = 1'h0, take = 1'h0;
	logic [1:0] req = 2'h0;
	logic wlanPin, btPin, regulatorEn, wlanResetN, btResetN, wlanPullEn, btPullEn;
	logic refClkBufEn, inputRxEn, outputEn, stateClear;
	logic [7:0] want[$];
	int err_count = 0, compares = 0, pulses = 0, ups = 0;
	always #5 clk = ~clk;
	host_pin_driver i_host_pin_driver (.clk(clk), .req(req), .wlanPin(wlanPin), .btPin(btPin));
	radio_power_enable_reset_ctrl i_radio_power_enable_reset_ctrl (.clk(clk), .srst(srst),
		.wlan_power_on_ctl(wlanPin), .bt_power_on_ctl(btPin), .sleepReq(sleepReq),
		.wlanPullDis(wlanPullDis), .btPullDis(btPullDis), .regulatorEn(regulatorEn),
		.wlanResetN(wlanResetN), .btResetN(btResetN), .wlanPullEn(wlanPullEn), .btPullEn(btPullEn),
		.refClkBufEn(refClkBufEn), .inputRxEn(inputRxEn), .outputEn(outputEn), .stateClear(stateClear));
	wire logic [7:0] got = {regulatorEn, wlanResetN, btResetN, outputEn, inputRxEn, refClkBufEn, wlanPullEn, btPullEn};
	always @(posedge clk) begin
		if (stateClear === 1'h1)
			pulses++;
		if (take === 1'h1) begin
			compares++;
			if (got !== want[0]) begin
				err_count++;
				$display("Error at %0t: outputs %h expected %h", $time, got, want[0]);
			end
			void'(want.pop_front());
		end
	end
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// levels settle within six edges of a pin change; eight leaves margin
	task automatic step(input logic [1:0] r, input logic s, input logic [1:0] p);
		@(posedge clk);
		if (req == 2'h0 && r != 2'h0)
			ups++;
		req <= r;
		sleepReq <= s;
		{wlanPullDis, btPullDis} <= p;
		repeat (8) @(posedge clk);
		want.push_back({|r, r[1], r[0], |r, |r, ~(s & |r), ~p});
		take <= 1'h1;
		@(posedge clk);
		take <= 1'h0;
		$display("test with enables %b sleep %b pull off %b done", r, s, p);
	endtask
	// mid-run reset with the pins still driven: all outputs return to their reset levels,
	// and a driven enable wakes the block once more after the release
	task automatic reset_pulse;
		@(posedge clk);
		srst <= 1'h1;
		repeat (2) @(posedge clk);
		if (req != 2'h0)
			ups++;
		// regulators off, resets held, outputs floated, buffer and both pull-downs on
		want.push_back(8'h07);
		srst <= 1'h0;
		take <= 1'h1;
		@(posedge clk);
		take <= 1'h0;
		$display("test with reset in mid-run done");
	endtask
	// the tests take about 500 cycles; 10000 cycles leave a wide margin
	initial begin
		#100000;
		err_count++;
		close_out;
	end
	initial begin
		void'($urandom(76072));
		repeat (20) @(posedge clk);
		srst <= 1'h0;
		for (int i = 0; i < 4; i++)
			step(i[1:0], 1'h0, 2'h0);
		step(2'h2, 1'h1, 2'h0);
		step(2'h0, 1'h1, 2'h3);
		step(2'h1, 1'h0, 2'h1);
		reset_pulse;
		repeat (40) step(2'($urandom), 1'($urandom), 2'($urandom));
		compares++;
		if (pulses !== ups) begin
			err_count++;
			$display("Error at %0t: %0d clear pulses for %0d power-ups", $time, pulses, ups);
		end
		close_out;
	end
endmodule
